/* design/quad_switch_regs.vh */
// Constants of the quad switch serial control block: frame layout,
// command addresses, field positions, status layout and watchdog timing.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef QUAD_SWITCH_REGS_VH
`define QUAD_SWITCH_REGS_VH

// Frame layout, most significant bit first
`define FRAME_BITS       16
`define FRAME_MSB        15
`define FRAME_WD_BIT     15
`define ADDR_MSB         14
`define ADDR_LSB         10
`define FRAME_COUNT_FULL 5'h10

// Command addresses
`define ADDR_OUT_CTRL    5'h01
`define ADDR_IN_CFG      5'h02
`define ADDR_WD_CFG      5'h03
`define ADDR_MON_CFG     5'h04

// Field positions inside the data part of a frame
`define OUT_CMD_LSB      0
`define IN_EN_LSB        0
`define IN_AND_LSB       4
`define WD_SEL_LSB       0
`define MON_SEL_LSB      0
`define MON_HIZ_BIT      2

// Reset values of the configuration fields
`define CMD_RESET        4'h0
`define SEL_RESET        2'h0
`define STATUS_RESET     16'h0000

// Status word returned on data out
`define STAT_OUT_LSB     12
`define STAT_IN_LSB      8
`define STAT_FAULT_BIT   7
`define STAT_FSI_BIT     6
`define STAT_WAKE_BIT    5
`define STAT_WDSEL_LSB   3
`define STAT_WATCHDOG_EXPIRED_FLAG_BIT    2
`define STAT_MON_LSB     0

// Fail-safe select pin codes and the output patterns they give
`define FSI_GROUNDED     2'h0
`define FSI_ALL_OFF      2'h1
`define FSI_HS0_ON       2'h2
`define FSI_OPEN         2'h3
`define FS_PAT_ALL_OFF   4'h0
`define FS_PAT_HS0       4'h1
`define FS_PAT_HS0_HS2   4'h5

// Watchdog timing: clock rate, tick period and timeouts in ms
`define CLK_MHZ          20
`define WD_TICK_US       1000
`define WDTO0_MS         12'h022E
`define WDTO1_MS         12'h0117
`define WDTO2_MS         12'h08CA
`define WDTO3_MS         12'h0465

`endif

/* design/serial_frame_shifter.v */
// Serial frame engine: pin synchronisers, edge finding, receive and
// transmit shift registers and the data-out driver enable.
// Assumes the host clock idles low and stays well below clk_sys / 4.
`timescale 1ns/100ps
`include "quad_switch_regs.vh"

module serial_frame_shifter (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        cs_n_pin,
   input  wire        sclk_pin,
   input  wire        sdi_pin,
   input  wire [15:0] status_word,
   output reg  [15:0] frame_word,
   output reg         frame_done,
   output reg         cs_fall,
   output reg         sdo,
   output reg         sdo_oe
);

   reg  [1:0]  cs_sync;
   reg  [1:0]  sclk_sync;
   reg  [1:0]  sdi_sync;
   reg         cs_prev;
   reg         sclk_prev;
   reg  [15:0] rx_shift;
   reg  [15:0] tx_shift;
   reg  [4:0]  bit_count;
   wire        cs_low;
   wire        cs_fall_w;
   wire        cs_rise_w;
   wire        sclk_rise;
   wire        sclk_fall;

   // Two flops per pin; the first stage feeds only the second
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         cs_sync   <= 2'h3;
         sclk_sync <= 2'h0;
         sdi_sync  <= 2'h0;
         cs_prev   <= 1'b1;
         sclk_prev <= 1'b0;
      end else begin
         cs_sync   <= {cs_sync[0], cs_n_pin};
         sclk_sync <= {sclk_sync[0], sclk_pin};
         sdi_sync  <= {sdi_sync[0], sdi_pin};
         cs_prev   <= cs_sync[1];
         sclk_prev <= sclk_sync[1];
      end
   end

   // Clock edges only count while select is low
   assign cs_low    = ~cs_sync[1];
   assign cs_fall_w = ~cs_sync[1] & cs_prev;
   assign cs_rise_w = cs_sync[1] & ~cs_prev;
   assign sclk_rise = cs_low & sclk_sync[1] & ~sclk_prev;
   assign sclk_fall = cs_low & ~sclk_sync[1] & sclk_prev;

   // Receive side: sample on falling clock, commit on select release
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_shift   <= `STATUS_RESET;
         bit_count  <= 5'h00;
         frame_word <= `STATUS_RESET;
         frame_done <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         if (cs_fall_w) begin
            bit_count <= 5'h00;
         end else if (sclk_fall) begin
            rx_shift <= {rx_shift[14:0], sdi_sync[1]};
            if (bit_count != 5'h1F) begin
               bit_count <= bit_count + 5'h01; // Saturates so long frames stay invalid
            end
         end
         // Only a frame of exactly sixteen bits is taken
         if (cs_rise_w && bit_count == `FRAME_COUNT_FULL) begin
            frame_word <= rx_shift;
            frame_done <= 1'b1;
         end
      end
   end

   // Transmit side: load on select fall, shift on rising clock
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_shift <= `STATUS_RESET;
         sdo      <= 1'b0;
         sdo_oe   <= 1'b0;
         cs_fall  <= 1'b0;
      end else begin
         cs_fall <= cs_fall_w;
         sdo_oe  <= cs_low;
         if (cs_fall_w) begin
            tx_shift <= status_word;
            sdo      <= status_word[`FRAME_MSB];
         end else if (sclk_rise) begin
            sdo      <= tx_shift[`FRAME_MSB];
            tx_shift <= {tx_shift[14:0], 1'b0};
         end
      end
   end

endmodule // serial_frame_shifter

/* design/quad_switch_serial_control.v */
// Top of the quad switch serial control: command registers, input
// combining, fault flag, sleep, watchdog and fail-safe output patterns.
// Assumes all pins are asynchronous to clk_sys and the analog side hands
// in per-channel fault levels and a two-bit fail-safe resistor code.
`timescale 1ns/100ps
`include "quad_switch_regs.vh"

// Overview of operation
// - Serial clock and data are ignored while select is high.
// - Select rising edge writes the received frame to the addressed register.
// - Select falling edge loads current status into the transmit register.
// - Data-out is driven only while select is low.
// - Each input bit is sampled on a falling serial clock edge.
// - Data-out changes on a rising serial clock edge.
// - A transfer is exactly sixteen bits, bit fifteen first.
// - A five-bit address field selects the written register.
// - Each direct input drives its matching power output.
// - Serial setting enables each input and picks OR or AND combining.
// - Fault flag pulls low on any fault; causes reported serially.
// - Reset low clears configuration and fault registers; sleep needs wake low too.
// - Reset pin rising edge starts the watchdog.
// - Serial settings pick the monitored output and can float the monitor pin.
// - Grounded fail-safe pin disables watchdog and fail-safe.
// - After timeout outputs follow the fail-safe pin pattern.
// - Data-out reports outputs, configuration and key input pins.
// - Wake and reset both low: sleep, outputs off, settings cleared.
// - Fail-safe ends on wake and reset falling together or pin grounded.
// - Watchdog timeout status bit reads one while in fail-safe.
module quad_switch_serial_control #(
   parameter integer TICK_CYCLES = `WD_TICK_US * `CLK_MHZ
) (
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire       cs_n_pin,
   input  wire       sclk_pin,
   input  wire       sdi_pin,
   input  wire [3:0] direct_drive_inputs,
   input  wire [3:0] channel_fault,
   input  wire       wake_pin,
   input  wire       device_reset_n_pin,
   input  wire [1:0] failsafe_select_pin,
   output wire       sdo,
   output wire       sdo_oe,
   output reg  [3:0] power_switch_outputs,
   output reg        fault_flag_n_out,
   output reg        fault_flag_n_oe,
   output reg  [1:0] current_monitor_sel,
   output reg        current_monitor_oe,
   output reg        sleep_mode,
   output reg        watchdog_expired_flag
);

   localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
   localparam [14:0] TICK_LAST   = TICK_LAST_W[14:0];

   // Asynchronous pin bundle: direct, fault, wake, reset, fail-safe code
   reg  [11:0] pin_meta;
   reg  [11:0] pin_sync;
   wire [3:0]  direct_sync;
   wire [3:0]  fault_sync;
   wire        wake_sync;
   wire        dev_reset_n_sync;
   wire [1:0]  fsi_sync;
   reg         wake_prev;
   reg         dev_reset_n_prev;

   // Serial side
   wire [15:0] frame_word;
   wire        frame_done;
   wire        cs_fall;
   reg  [15:0] status_word;
   wire [4:0]  frame_addr;

   // Command and configuration registers
   reg  [3:0]  out_cmd;
   reg  [3:0]  in_enable;
   reg  [3:0]  in_and_mode;
   reg  [1:0]  wd_select;
   reg  [1:0]  mon_select;
   reg         mon_hiz;
   reg  [3:0]  fault_latch;

   // Watchdog and fail-safe
   reg         wd_running;
   reg         wd_last_bit;
   reg  [14:0] tick_count;
   reg  [11:0] ms_count;
   reg         in_failsafe;
   wire        fsi_grounded;
   wire        wd_start;
   wire        wd_kick;
   wire        wd_timeout;
   wire        leave_failsafe;
   wire        config_clear;

   // Output drive
   wire [3:0]  chan_request;
   reg  [3:0]  failsafe_pattern;
   reg  [3:0]  next_outputs;

   // True when the frame address equals the given register address
   function addr_hit;
      input [4:0] addr;
      input [4:0] code;
      begin
         addr_hit = (addr == code);
      end
   endfunction

   // Watchdog limit in ms for each timeout setting
   function [11:0] wd_limit;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    wd_limit = `WDTO0_MS;
            2'h1:    wd_limit = `WDTO1_MS;
            2'h2:    wd_limit = `WDTO2_MS;
            default: wd_limit = `WDTO3_MS;
         endcase
      end
   endfunction

   serial_frame_shifter u_shifter (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .cs_n_pin    (cs_n_pin),
      .sclk_pin    (sclk_pin),
      .sdi_pin     (sdi_pin),
      .status_word (status_word),
      .frame_word  (frame_word),
      .frame_done  (frame_done),
      .cs_fall     (cs_fall),
      .sdo         (sdo),
      .sdo_oe      (sdo_oe)
   );

   // Two-flop synchronisers; the reset pin syncs low so we start asleep
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_meta <= 12'h000;
         pin_sync <= 12'h000;
      end else begin
         pin_meta <= {failsafe_select_pin, device_reset_n_pin, wake_pin,
                      channel_fault, direct_drive_inputs};
         pin_sync <= pin_meta;
      end
   end

   assign direct_sync      = pin_sync[3:0];
   assign fault_sync       = pin_sync[7:4];
   assign wake_sync        = pin_sync[8];
   assign dev_reset_n_sync = pin_sync[9];
   assign fsi_sync         = pin_sync[11:10];

   // Previous levels for edge finding on wake and reset
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         wake_prev        <= 1'b0;
         dev_reset_n_prev <= 1'b0;
      end else begin
         wake_prev        <= wake_sync;
         dev_reset_n_prev <= dev_reset_n_sync;
      end
   end

   assign frame_addr   = frame_word[`ADDR_MSB:`ADDR_LSB];
   assign fsi_grounded = (fsi_sync == `FSI_GROUNDED);
   // Reset low alone clears settings; with wake low too the part sleeps
   assign config_clear = ~dev_reset_n_sync;

   // Command registers written from complete frames
   always @(posedge clk_sys) begin
      if (!rst_n || config_clear) begin
         out_cmd     <= `CMD_RESET;
         in_enable   <= `CMD_RESET;
         in_and_mode <= `CMD_RESET;
         wd_select   <= `SEL_RESET;
         mon_select  <= `SEL_RESET;
         mon_hiz     <= 1'b0;
      end else if (frame_done) begin
         if (addr_hit(frame_addr, `ADDR_OUT_CTRL)) begin
            out_cmd <= frame_word[`OUT_CMD_LSB+3:`OUT_CMD_LSB];
         end
         if (addr_hit(frame_addr, `ADDR_IN_CFG)) begin
            in_enable   <= frame_word[`IN_EN_LSB+3:`IN_EN_LSB];
            in_and_mode <= frame_word[`IN_AND_LSB+3:`IN_AND_LSB];
         end
         if (addr_hit(frame_addr, `ADDR_WD_CFG)) begin
            wd_select <= frame_word[`WD_SEL_LSB+1:`WD_SEL_LSB];
         end
         if (addr_hit(frame_addr, `ADDR_MON_CFG)) begin
            mon_select <= frame_word[`MON_SEL_LSB+1:`MON_SEL_LSB];
            mon_hiz    <= frame_word[`MON_HIZ_BIT];
         end
      end
   end

   // Latched fault causes; a new fault beats the read-clear in one cycle
   always @(posedge clk_sys) begin
      if (!rst_n || config_clear) begin
         fault_latch <= `CMD_RESET;
      end else if (cs_fall) begin
         fault_latch <= fault_sync;
      end else begin
         fault_latch <= fault_latch | fault_sync;
      end
   end

   // Status snapshot kept one cycle ahead of the select falling edge
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         status_word <= `STATUS_RESET;
      end else begin
         status_word <= `STATUS_RESET;
         status_word[`STAT_OUT_LSB+3:`STAT_OUT_LSB] <= power_switch_outputs;
         status_word[`STAT_IN_LSB+3:`STAT_IN_LSB]   <= fault_latch | fault_sync;
         status_word[`STAT_FAULT_BIT]               <= |(fault_latch | fault_sync);
         status_word[`STAT_FSI_BIT]                 <= ~fsi_grounded;
         status_word[`STAT_WAKE_BIT]                <= wake_sync;
         status_word[`STAT_WDSEL_LSB+1:`STAT_WDSEL_LSB] <= wd_select;
         status_word[`STAT_WATCHDOG_EXPIRED_FLAG_BIT]                <= in_failsafe;
         status_word[`STAT_MON_LSB+1:`STAT_MON_LSB] <= mon_select;
      end
   end

   // Watchdog starts on a rising reset or wake, unless fail-safe is grounded
   assign wd_start = ((dev_reset_n_sync & ~dev_reset_n_prev) |
                      (wake_sync & ~wake_prev)) & ~fsi_grounded;
   // The host proves life by flipping bit fifteen between frames
   assign wd_kick    = frame_done & (frame_word[`FRAME_WD_BIT] != wd_last_bit);
   assign wd_timeout = wd_running & (ms_count >= wd_limit(wd_select));
   // Both pins must drop in the same sample; one at a time keeps fail-safe
   assign leave_failsafe = (wake_prev & dev_reset_n_prev & ~wake_sync &
                            ~dev_reset_n_sync) | fsi_grounded;

   // Millisecond prescaler and timeout counter
   always @(posedge clk_sys) begin
      if (!rst_n || fsi_grounded || !wd_running || wd_start || wd_kick) begin
         tick_count <= 15'h0000;
         ms_count   <= 12'h000;
      end else if (tick_count == TICK_LAST) begin
         tick_count <= 15'h0000;
         if (ms_count != 12'hFFF) begin
            ms_count <= ms_count + 12'h001;
         end
      end else begin
         tick_count <= tick_count + 15'h0001;
      end
   end

   // Watchdog run state and fail-safe latch
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         wd_running  <= 1'b0;
         wd_last_bit <= 1'b0;
         in_failsafe <= 1'b0;
      end else begin
         if (frame_done) begin
            wd_last_bit <= frame_word[`FRAME_WD_BIT];
         end
         if (fsi_grounded) begin
            wd_running <= 1'b0;
         end else if (wd_start) begin
            wd_running <= 1'b1;
         end else if (wd_timeout) begin
            wd_running <= 1'b0;
         end
         if (wd_timeout && !fsi_grounded) begin
            in_failsafe <= 1'b1;
         end else if (leave_failsafe) begin
            in_failsafe <= 1'b0;
         end
      end
   end

   // Per-channel combination of direct input and serial command
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
         assign chan_request[ch] = !in_enable[ch] ? out_cmd[ch] :
                                   in_and_mode[ch] ? (out_cmd[ch] & direct_sync[ch]) :
                                   (out_cmd[ch] | direct_sync[ch]);
      end
   endgenerate

   // Output pattern chosen by the fail-safe resistor
   always @* begin
      case (fsi_sync)
         `FSI_ALL_OFF: failsafe_pattern = `FS_PAT_ALL_OFF;
         `FSI_HS0_ON:  failsafe_pattern = `FS_PAT_HS0;
         `FSI_OPEN:    failsafe_pattern = `FS_PAT_HS0_HS2;
         default:      failsafe_pattern = `FS_PAT_ALL_OFF;
      endcase
   end

   // Priority: sleep, then fail-safe, then normal with faulted channels off
   always @* begin
      if (!wake_sync && !dev_reset_n_sync) begin
         next_outputs = `CMD_RESET;
      end else if (in_failsafe) begin
         next_outputs = failsafe_pattern;
      end else begin
         next_outputs = chan_request & ~fault_sync;
      end
   end

   // Registered pin outputs
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         power_switch_outputs  <= `CMD_RESET;
         fault_flag_n_out      <= 1'b0;
         fault_flag_n_oe       <= 1'b0;
         current_monitor_sel   <= `SEL_RESET;
         current_monitor_oe    <= 1'b0;
         sleep_mode            <= 1'b1;
         watchdog_expired_flag <= 1'b0;
      end else begin
         power_switch_outputs  <= next_outputs;
         fault_flag_n_out      <= 1'b0; // Open drain only ever pulls low
         fault_flag_n_oe       <= |(fault_latch | fault_sync);
         current_monitor_sel   <= mon_select;
         current_monitor_oe    <= ~mon_hiz & ~sleep_mode;
         sleep_mode            <= ~wake_sync & ~dev_reset_n_sync;
         watchdog_expired_flag <= in_failsafe;
      end
   end

endmodule // quad_switch_serial_control

/* sim/quad_switch_checker_asserts.sv */
// Checker for the quad switch serial control: pin-level relations.
// Assumes one clk_sys domain with rst_n as its synchronous reset.
`timescale 1ns/100ps
`include "quad_switch_regs.vh"
module quad_switch_checker (
   input wire       clk_sys,
   input wire       rst_n,
   input wire       cs_n_pin,
   input wire [3:0] channel_fault,
   input wire       wake_pin,
   input wire       device_reset_n_pin,
   input wire [1:0] failsafe_select_pin,
   input wire       sdo_oe,
   input wire [3:0] power_switch_outputs,
   input wire       fault_flag_n_out,
   input wire       fault_flag_n_oe,
   input wire       sleep_mode,
   input wire       watchdog_expired_flag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Pins cross two sync flops and a register, so five cycles settle them
   sequence cs_held_high; cs_n_pin [*5]; endsequence
   sequence cs_held_low; !cs_n_pin [*5]; endsequence
   sequence both_low; (!wake_pin && !device_reset_n_pin) [*5]; endsequence
   sequence fs_open_held;
      (watchdog_expired_flag && !sleep_mode && failsafe_select_pin == `FSI_OPEN) [*5];
   endsequence

   chk_sdo_idle: assert property (cs_held_high |-> !sdo_oe)
      else $error("data out driven while deselected");
   chk_sdo_active: assert property (cs_held_low |-> sdo_oe)
      else $error("data out not driven while selected");
   chk_sleep_entry: assert property (both_low |-> sleep_mode)
      else $error("no sleep with wake and reset low");
   chk_wake_run: assert property (wake_pin [*5] |-> !sleep_mode)
      else $error("sleep while wake high");
   chk_sleep_off: assert property (
      sleep_mode [*3] |-> power_switch_outputs == 4'h0)
      else $error("output on in sleep");
   chk_fault_pull: assert property (
      (channel_fault != 4'h0) [*5] |-> fault_flag_n_oe)
      else $error("fault flag not pulled on fault");
   chk_flag_level: assert property (fault_flag_n_oe |-> !fault_flag_n_out)
      else $error("fault flag driven high");
   chk_fs_pattern: assert property (
      fs_open_held |-> power_switch_outputs == `FS_PAT_HS0_HS2)
      else $error("wrong fail-safe pattern");
   chk_fsi_grounded: assert property (
      (failsafe_select_pin == `FSI_GROUNDED) [*5] |-> !watchdog_expired_flag)
      else $error("fail-safe with grounded select");
endmodule // quad_switch_checker

/* sim/host_model.sv */
// Host model: serial bus master framing words on select, clock, data in.
// Assumes clk_sys at 20 MHz; one link clock period is 8 clk_sys.
`timescale 1ns/100ps
module host_model (
   input  wire clk_sys,
   input  wire sdo,
   input  wire sdo_oe,
   output reg  cs_n_pin,
   output reg  sclk_pin,
   output reg  sdi_pin
);
   // Idle deselected with the clock low
   initial begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      sdi_pin  = 1'b0;
   end

   // Half a link period; changes land just after an edge
   task automatic half;
      begin
         repeat (4) @(posedge clk_sys);
         #1;
      end
   endtask

   // Frame of n clocks; sel low clocks with select left high
   task automatic xfer(input [15:0] w, input [4:0] n, input sel, output [15:0] r);
      integer i;
      begin
         r = 16'h0000;
         cs_n_pin = ~sel;
         for (i = 0; i < n; i = i + 1) begin
            half;
            sclk_pin = 1'b1;
            sdi_pin  = w[15 - i];
            half;
            sclk_pin = 1'b0;
            r = {r[14:0], sdo_oe ? sdo : 1'bx};
         end
         half;
         cs_n_pin = 1'b1;
         sdi_pin  = ~sdi_pin; // Stale data must not pass for valid
         half;
         half;
      end
   endtask
endmodule // host_model

/* sim/tb_top.sv */
// Bench for the quad switch serial control: frames via the host model.
// Assumes TICK_CYCLES of 20, so one watchdog ms is 20 clk_sys.
`timescale 1ns/100ps
`include "quad_switch_regs.vh"
module tb_top;
   reg         clk_sys;
   reg         rst_n;
   reg  [3:0]  direct_drive_inputs;
   reg  [3:0]  channel_fault;
   reg         wake_pin;
   reg         device_reset_n_pin;
   reg  [1:0]  failsafe_select_pin;
   reg         wd;
   reg  [15:0] rx;
   wire        cs_n_pin, sclk_pin, sdi_pin, sdo, sdo_oe;
   wire [3:0]  power_switch_outputs;
   wire        fault_flag_n_out, fault_flag_n_oe, current_monitor_oe;
   wire [1:0]  current_monitor_sel;
   wire        sleep_mode, watchdog_expired_flag;
   integer     mismatches, comparisons, cycles;

   quad_switch_serial_control #(.TICK_CYCLES(20)) quad_switch_serial_control_inst (
      .clk_sys, .rst_n, .cs_n_pin, .sclk_pin, .sdi_pin, .direct_drive_inputs,
      .channel_fault, .wake_pin, .device_reset_n_pin, .failsafe_select_pin,
      .sdo, .sdo_oe, .power_switch_outputs, .fault_flag_n_out, .fault_flag_n_oe,
      .current_monitor_sel, .current_monitor_oe, .sleep_mode, .watchdog_expired_flag);
   host_model host_model_inst (.clk_sys, .sdo, .sdo_oe, .cs_n_pin, .sclk_pin, .sdi_pin);

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Run is about 25500 cycles; a hang is cut at 60000, over twice that
   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 60000) begin
         mismatches = mismatches + 1;
         end_of_test;
      end
   end

   task tick(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask

   task check(input string name, input [15:0] seen, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask

   // Command frame; bit 15 flips every time to keep the watchdog fed
   task wr(input [4:0] a, input [9:0] d);
      begin
         wd = ~wd;
         host_model_inst.xfer({wd, a, d}, 5'h10, 1'b1, rx);
      end
   endtask

   // Bounded wait for the fail-safe flag
   task wait_wdx(input integer n);
      integer i;
      begin
         for (i = 0; i < n && watchdog_expired_flag !== 1'b1; i = i + 1)
            tick(1);
      end
   endtask

   task end_of_test;
      begin
         $display("mismatches %0d comparisons %0d", mismatches, comparisons);
         if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      direct_drive_inputs = 4'h0;
      channel_fault = 4'h0;
      wake_pin = 1'b0;
      device_reset_n_pin = 1'b0;
      failsafe_select_pin = `FSI_OPEN;
      wd = 1'b0;
      mismatches = 0;
      comparisons = 0;
      cycles = 0;
      tick(4);
      check("sleep_rst", sleep_mode, 1'b1);
      check("flag_rst", fault_flag_n_oe, 1'b0);
      rst_n = 1'b1;
      wake_pin = 1'b1;
      device_reset_n_pin = 1'b1;
      tick(8);
      check("awake", sleep_mode, 1'b0);
      wr(`ADDR_OUT_CTRL, 10'h005);
      check("outs", power_switch_outputs, 4'h5);
      check("sdo_oe", sdo_oe, 1'b0);
      host_model_inst.xfer(16'h040A, 5'h10, 1'b0, rx);
      host_model_inst.xfer(16'h040A, 5'h08, 1'b1, rx);
      check("ignored", power_switch_outputs, 4'h5);
      direct_drive_inputs = 4'hA;
      wr(`ADDR_IN_CFG, 10'h000);
      check("status", rx, 16'h5060);
      wr(`ADDR_IN_CFG, 10'h00F);
      check("or_all", power_switch_outputs, 4'hF);
      wr(`ADDR_IN_CFG, 10'h0FF);
      check("and_all", power_switch_outputs, 4'h0);
      wr(`ADDR_IN_CFG, 10'h00C);
      check("part_en", power_switch_outputs, 4'hD);
      wr(`ADDR_MON_CFG, 10'h002);
      check("mon_sel", current_monitor_sel, 2'h2);
      check("mon_on", current_monitor_oe, 1'b1);
      wr(`ADDR_MON_CFG, 10'h006);
      check("mon_hiz", current_monitor_oe, 1'b0);
      channel_fault = 4'h1;
      tick(6);
      check("fault_oe", fault_flag_n_oe, 1'b1);
      check("flag_low", fault_flag_n_out, 1'b0);
      check("fault_outs", power_switch_outputs, 4'hC);
      wr(`ADDR_OUT_CTRL, 10'h005);
      check("fault_st", rx, 16'hC1E2);
      channel_fault = 4'h0;
      wr(`ADDR_WD_CFG, 10'h001);
      tick(5400);
      check("wd_early", watchdog_expired_flag, 1'b0);
      wait_wdx(400);
      check("wd_late", watchdog_expired_flag, 1'b1);
      tick(6);
      check("fs_open", power_switch_outputs, `FS_PAT_HS0_HS2);
      wr(`ADDR_OUT_CTRL, 10'h005);
      check("watchdog_expired_flag_bit", rx[2], 1'b1);
      check("wdsel_st", rx[4:3], 2'h1);
      failsafe_select_pin = `FSI_HS0_ON;
      tick(6);
      check("fs_hs0", power_switch_outputs, `FS_PAT_HS0);
      failsafe_select_pin = `FSI_ALL_OFF;
      tick(6);
      check("fs_off", power_switch_outputs, `FS_PAT_ALL_OFF);
      failsafe_select_pin = `FSI_GROUNDED;
      tick(6);
      check("fs_exit", watchdog_expired_flag, 1'b0);
      check("normal", power_switch_outputs, 4'hD);
      // A wake rise would start the watchdog were the grounded pin not obeyed
      wake_pin = 1'b0;
      tick(6);
      wake_pin = 1'b1;
      tick(7000);
      check("wd_off", watchdog_expired_flag, 1'b0);
      failsafe_select_pin = `FSI_OPEN;
      wake_pin = 1'b0;
      device_reset_n_pin = 1'b0;
      tick(6);
      check("sleep_in", sleep_mode, 1'b1);
      check("sleep_outs", power_switch_outputs, 4'h0);
      device_reset_n_pin = 1'b1;
      tick(6);
      check("cleared", power_switch_outputs, 4'h0);
      tick(11000);
      check("wd_run", watchdog_expired_flag, 1'b0);
      wait_wdx(400);
      check("wd_start", watchdog_expired_flag, 1'b1);
      end_of_test;
   end
endmodule // tb_top

bind quad_switch_serial_control quad_switch_checker quad_switch_checker_inst (
   .clk_sys, .rst_n, .cs_n_pin, .channel_fault, .wake_pin, .device_reset_n_pin,
   .failsafe_select_pin, .sdo_oe, .power_switch_outputs, .fault_flag_n_out,
   .fault_flag_n_oe, .sleep_mode, .watchdog_expired_flag);
